// ==== ccp_consts.svh ====
// Purpose: constants of the codec control port
// Assumes: included by bare name; definitions only
// Notes:   widths, addresses and counts as macros
// What this block does
// - two-wire bus accepts register writes and reads
// - two-wire address 0x20 strap low, 0x22 high
// - host drives select; SPI chip address 0x20
// - write: address, register byte, data; two-wire adds acks
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
// ====================================================
// bus addresses
`define CCP_ADDR_PREFIX   6'h08
`define CCP_I2C_ADDR_LO   8'h20
`define CCP_I2C_ADDR_HI   8'h22
`define CCP_SPI_ADDR      8'h20
// ====================================================
// framing counts
`define CCP_BYTE_BITS     4'h8
`define CCP_SPI_BITS      5'h18
`define CCP_SPI_LAST      5'h17
// ====================================================
// strap capture: edges after release before the syncs hold pin levels
`define CCP_STRAP_WAIT    2'h3
`endif

// ==== ccp_pkg.sv ====
// Purpose: shared types of the codec control port
// Assumes: nothing
// Notes:   constants live in ccp_consts.svh
package ccp_pkg;
  // ==================================================
  // two-wire engine states
  typedef enum logic [2:0] {
    CCP_IDLE,     // waiting for a start
    CCP_RX,       // receiving a byte
    CCP_ACK,      // driving the acknowledge bit
    CCP_TX,       // sending a read byte
    CCP_HOST_ACK  // sampling host acknowledge
  } ccp_state_t;
endpackage : ccp_pkg

// ==== ccp_spi_rx.sv ====
// Purpose: SPI-style receiver on the link clock
// Assumes: select active low frames the transfer
// Notes:   a full word flips a toggle for the core clock
`timescale 1ns/1ns
`include "ccp_consts.svh"
module ccp_spi_rx (
  // link side
  input  wire logic        link_clk,
  input  wire logic        select_n,
  input  wire logic        link_data,
  // reset
  input  wire logic        rst_n,
  // word out, held until the next word
  output logic [23:0]      word_reg,
  output logic             word_tgl_reg
);
  // ==================================================
  // frame state
  logic [23:0] shift_reg;   // bits so far, msb first
  logic [4:0]  cnt_reg;     // bits so far
  logic        frame_rst;   // ends the frame

  assign frame_rst = select_n | ~rst_n;

  // shifter, cleared whenever select is high
  always_ff @(posedge link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      shift_reg <= 24'h000000;
      cnt_reg   <= 5'h00;
    end else begin
      shift_reg <= {shift_reg[22:0], link_data};
      if (cnt_reg != `CCP_SPI_BITS) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // capture word on the last bit; only global reset clears
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg     <= 24'h000000;
      word_tgl_reg <= 1'b0;
    end else if (!select_n && cnt_reg == `CCP_SPI_LAST) begin
      word_reg     <= {shift_reg[22:0], link_data};
      word_tgl_reg <= ~word_tgl_reg;
    end
  end
endmodule : ccp_spi_rx

// ==== ccp_top.sv ====
// Purpose: codec control port, two-wire and SPI-style slave
// Assumes: mode and select straps stable around reset release
// Notes:   two-wire engine oversamples pins on mclk
`timescale 1ns/1ns
`include "ccp_consts.svh"
module ccp_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // straps and select
  input  wire logic        spi_mode_strap,
  input  wire logic        address_low_bit,
  // serial pins
  input  wire logic        control_clock_pin,
  input  wire logic        control_data_pin_i,
  output logic             control_data_pin_o,
  output logic             control_data_pin_oe,
  // register side
  output logic             reg_wr_pulse,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  // ==================================================
  // pin synchronisers
  logic [1:0] scl_sync;     // clock pin, two stages
  logic [1:0] sda_sync;     // data pin, two stages
  logic [1:0] sel_sync;     // select pin, two stages
  logic       scl_prev;     // previous synced clock
  logic       sda_prev;     // previous synced data

  // two flops before the two-wire and strap logic read a pin; the SPI receiver takes pins directly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], control_clock_pin};
      sda_sync <= {sda_sync[0], control_data_pin_i};
      sel_sync <= {sel_sync[0], address_low_bit};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // ==================================================
  // strap capture after reset release
  logic spi_mode_reg;       // 1: SPI-style bus
  logic strap_sel_reg;      // two-wire address bit
  logic strap_done_reg;     // straps captured
  logic spi_mode_s0;        // mode strap first stage
  logic spi_mode_s1;        // mode strap second stage
  logic [1:0] strap_wait_reg; // edges since reset release

  // straps are pins, synced then latched once
  // waits until the syncs carry pin levels, not their reset values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_mode_s0    <= 1'b0;
      spi_mode_s1    <= 1'b0;
      spi_mode_reg   <= 1'b0;
      strap_sel_reg  <= 1'b0;
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end else begin
      spi_mode_s0 <= spi_mode_strap;
      spi_mode_s1 <= spi_mode_s0;
      if (strap_wait_reg != `CCP_STRAP_WAIT) begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
      if (!strap_done_reg && strap_wait_reg == `CCP_STRAP_WAIT &&
          scl_prev == scl_sync[1]) begin
        spi_mode_reg   <= spi_mode_s1;
        strap_sel_reg  <= sel_sync[1];
        strap_done_reg <= 1'b1;
      end
    end
  end

  // ==================================================
  // bus events
  logic       scl_rise;     // clock rising
  logic       scl_fall;     // clock falling
  logic       bus_start;    // data falls, clock high
  logic       bus_stop;     // data rises, clock high
  logic [7:0] my_addr;      // expected address byte

  assign scl_rise  = scl_sync[1] & ~scl_prev;
  assign scl_fall  = ~scl_sync[1] & scl_prev;
  assign bus_start = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign bus_stop  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  // prefix, strap bit, write direction
  assign my_addr   = {`CCP_ADDR_PREFIX, strap_sel_reg, 1'b0};

  // ==================================================
  // two-wire engine
  ccp_pkg::ccp_state_t state_reg; // engine state
  logic [7:0] shift_reg;    // byte in or out
  logic [3:0] bit_cnt_reg;  // bits of current byte
  logic [1:0] byte_idx_reg; // 0 addr, 1 reg, 2 data
  logic       read_reg;     // direction of transfer
  logic       ack_ok_reg;   // byte was acknowledged
  logic       i2c_wr;       // write from two-wire
  logic       i2c_inc;      // address step after read
  logic [7:0] rx_byte;      // completed byte

  assign rx_byte = shift_reg;

  // engine state, byte handling
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ccp_pkg::CCP_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
      read_reg     <= 1'b0;
      ack_ok_reg   <= 1'b0;
    end else if (spi_mode_reg || !strap_done_reg) begin
      state_reg <= ccp_pkg::CCP_IDLE;
    end else if (bus_start) begin
      // start or repeated start
      state_reg    <= ccp_pkg::CCP_RX;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
    end else if (bus_stop) begin
      state_reg <= ccp_pkg::CCP_IDLE;
    end else begin
      unique case (state_reg)
        ccp_pkg::CCP_IDLE: begin
          // nothing until a start
        end
        ccp_pkg::CCP_RX: begin
          if (scl_rise && bit_cnt_reg != `CCP_BYTE_BITS) begin
            shift_reg   <= {shift_reg[6:0], sda_sync[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == `CCP_BYTE_BITS) begin
            bit_cnt_reg <= 4'h0;
            if (byte_idx_reg == 2'h0) begin
              // address byte: match ignoring direction
              if (rx_byte[7:1] == my_addr[7:1]) begin
                read_reg     <= rx_byte[0];
                state_reg    <= ccp_pkg::CCP_ACK;
                byte_idx_reg <= 2'h1;
              end else begin
                state_reg <= ccp_pkg::CCP_IDLE;
              end
            end else begin
              state_reg <= ccp_pkg::CCP_ACK;
              if (byte_idx_reg == 2'h1) begin
                byte_idx_reg <= 2'h2;
              end
            end
          end
        end
        ccp_pkg::CCP_ACK: begin
          // ack ends on the next falling clock
          if (scl_fall) begin
            if (read_reg) begin
              state_reg   <= ccp_pkg::CCP_TX;
              shift_reg   <= reg_rdata;
              bit_cnt_reg <= 4'h0;
            end else begin
              state_reg <= ccp_pkg::CCP_RX;
            end
          end
        end
        ccp_pkg::CCP_TX: begin
          if (scl_fall) begin
            shift_reg   <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= ccp_pkg::CCP_HOST_ACK;
            end
          end
        end
        ccp_pkg::CCP_HOST_ACK: begin
          // no-ack ends the read; ack sends next byte
          if (scl_rise) begin
            ack_ok_reg <= ~sda_sync[1];
            if (sda_sync[1]) begin
              state_reg <= ccp_pkg::CCP_IDLE;
            end
          end else if (scl_fall && ack_ok_reg) begin
            state_reg   <= ccp_pkg::CCP_TX;
            shift_reg   <= reg_rdata;
            bit_cnt_reg <= 4'h0;
            ack_ok_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

  // data byte done, write direction
  assign i2c_wr  = (state_reg == ccp_pkg::CCP_RX) && scl_fall && !bus_start &&
                   !bus_stop && bit_cnt_reg == `CCP_BYTE_BITS &&
                   byte_idx_reg == 2'h2 && !spi_mode_reg;
  // step on the host ack, so the next byte loads from the new address
  assign i2c_inc = (state_reg == ccp_pkg::CCP_HOST_ACK) && scl_rise &&
                   !sda_sync[1] && !bus_start && !bus_stop && !spi_mode_reg;

  // ==================================================
  // data pin drive, open drain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_data_pin_o  <= 1'b0;
      control_data_pin_oe <= 1'b0;
    end else begin
      control_data_pin_o <= 1'b0;
      if (state_reg == ccp_pkg::CCP_ACK) begin
        control_data_pin_oe <= 1'b1;
      end else if (state_reg == ccp_pkg::CCP_TX) begin
        control_data_pin_oe <= ~shift_reg[7];
      end else begin
        control_data_pin_oe <= 1'b0;
      end
    end
  end

  // ==================================================
  // SPI-style receiver and its crossing
  logic [23:0] spi_word;    // held word, link domain
  logic        spi_tgl;     // flips per word, link domain
  logic [1:0]  tgl_sync;    // toggle, two stages
  logic        tgl_prev;    // toggle, last seen
  logic        spi_word_ok; // new word for this chip

  ccp_spi_rx u_spi_rx (
    .link_clk     (control_clock_pin),
    .select_n     (address_low_bit),
    .link_data    (control_data_pin_i),
    .rst_n        (rst_n),
    .word_reg     (spi_word),
    .word_tgl_reg (spi_tgl)
  );

  // toggle crossing into mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync <= 2'h0;
      tgl_prev <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[0], spi_tgl};
      tgl_prev <= tgl_sync[1];
    end
  end

  // word held stable long after its toggle flips
  assign spi_word_ok = spi_mode_reg && (tgl_sync[1] != tgl_prev) &&
                       spi_word[23:16] == `CCP_SPI_ADDR;

  // ==================================================
  // register side outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_pulse <= 1'b0;
      reg_addr     <= 8'h00;
      reg_wdata    <= 8'h00;
    end else begin
      reg_wr_pulse <= i2c_wr | spi_word_ok;
      if (spi_word_ok) begin
        // SPI carries writes only
        reg_addr  <= spi_word[15:8];
        reg_wdata <= spi_word[7:0];
      end else if (state_reg == ccp_pkg::CCP_RX && scl_fall &&
                   bit_cnt_reg == `CCP_BYTE_BITS && byte_idx_reg == 2'h1 &&
                   !bus_start && !bus_stop && !spi_mode_reg) begin
        reg_addr <= rx_byte;
      end else if (i2c_wr) begin
        reg_wdata <= rx_byte;
      end else if (reg_wr_pulse || i2c_inc) begin
        // step to next register after each write and each acked read byte
        reg_addr <= reg_addr + 8'h01;
      end
    end
  end
endmodule : ccp_top

// ==== ccp_properties.sv ====
// Purpose: concurrent checks on the control port pins
// Assumes: bound into ccp_top, pins sampled on mclk
// Notes:   counters time pin events in mclk cycles
`timescale 1ns/1ns
module ccp_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // straps and pins
  input wire logic       spi_mode_strap,
  input wire logic       address_low_bit,
  input wire logic       control_clock_pin,
  input wire logic       control_data_pin_i,
  input wire logic       control_data_pin_o,
  input wire logic       control_data_pin_oe,
  // register side
  input wire logic       reg_wr_pulse,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ==================================================
  // helper counters
  logic       clk_q;    // clock level one cycle ago
  logic [3:0] fall_cnt; // cycles since clock fell
  logic [3:0] hi_cnt;   // cycles clock stayed high
  logic [3:0] sel_cnt;  // cycles select stayed high
  // clock edge timing, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q    <= 1'b1;
      fall_cnt <= 4'hf;
      hi_cnt   <= 4'h0;
    end else begin
      clk_q    <= control_clock_pin;
      fall_cnt <= (clk_q && !control_clock_pin) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
      hi_cnt   <= control_clock_pin ? hi_cnt + {3'h0, hi_cnt != 4'hf} : 4'h0;
    end
  end
  // select high time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sel_cnt <= 4'h0;
    else sel_cnt <= address_low_bit ? sel_cnt + {3'h0, sel_cnt != 4'hf} : 4'h0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // assertions
  open_drain_a: assert property (!control_data_pin_o)
    else $error("data pin output not low");
  spi_quiet_a: assert property (spi_mode_strap |-> !control_data_pin_oe)
    else $error("data pin driven in spi mode");
  pulse_single_a: assert property (reg_wr_pulse |=> !reg_wr_pulse)
    else $error("write pulse longer than one cycle");
  addr_step_a: assert property (reg_wr_pulse |=> reg_addr == $past(reg_addr) + 8'h01)
    else $error("address did not step after write");
  reset_state_a: assert property ($rose(rst_n) |->
    !reg_wr_pulse && !control_data_pin_oe && reg_addr == 8'h00 && reg_wdata == 8'h00)
    else $error("outputs not cleared by reset");
  oe_hold_a: assert property (hi_cnt >= 4'h6 |-> $stable(control_data_pin_oe))
    else $error("data pin changed while clock high");
  oe_launch_a: assert property ($rose(control_data_pin_oe) |-> fall_cnt <= 4'h8)
    else $error("data pin pulled late after clock fall");
  i2c_write_a: assert property (!spi_mode_strap && reg_wr_pulse |-> fall_cnt <= 4'h8)
    else $error("write pulse not tied to a byte end");
  spi_write_a: assert property (spi_mode_strap && reg_wr_pulse |-> sel_cnt <= 4'h6)
    else $error("spi write outside a selected frame");
  // main scenarios
  cover property (reg_wr_pulse && !spi_mode_strap);
  cover property (reg_wr_pulse && spi_mode_strap);
  cover property ($rose(control_data_pin_oe));
endmodule : ccp_properties
bind ccp_top ccp_properties chk (
  .mclk(mclk), .rst_n(rst_n), .spi_mode_strap(spi_mode_strap),
  .address_low_bit(address_low_bit), .control_clock_pin(control_clock_pin),
  .control_data_pin_i(control_data_pin_i), .control_data_pin_o(control_data_pin_o),
  .control_data_pin_oe(control_data_pin_oe), .reg_wr_pulse(reg_wr_pulse),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
);

// ==== ccp_host_model.sv ====
// Purpose: host driving the two-wire and SPI-style buses
// Assumes: device pulls the data wire low through data_oe
// Notes:   two-wire phases are 8 mclk; SPI bit clock 48 ns
`timescale 1ns/1ns
module ccp_host_model (
  // pacing clock
  input  wire logic mclk,
  // device pull-down
  input  wire logic data_oe,
  // bus pins
  output logic      clk_pin,
  output logic      data_pin,
  output logic      sel_pin
);
  logic drv; // host data level, 1 releases the wire
  // pulled-up wire, low if either side pulls
  assign data_pin = drv & !data_oe;
  // select stays at its strap level in two-wire mode
  initial begin
    clk_pin = 1'b1;
    drv     = 1'b1;
    sel_pin = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask : half
  // start and repeated start
  task automatic start();
    half(); drv = 1'b1; half(); clk_pin = 1'b1; half(); drv = 1'b0; half(); clk_pin = 1'b0;
  endtask : start
  task automatic stop();
    half(); drv = 1'b0; half(); clk_pin = 1'b1; half(); drv = 1'b1; half();
  endtask : stop
  // one bit, data set mid low phase, wire read at end of high
  task automatic bitx(input logic b, output logic r);
    half(); drv = b; half(); clk_pin = 1'b1; half(); r = data_pin; clk_pin = 1'b0;
  endtask : bitx
  // byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
    bitx(last, ack);
  endtask : xfer
  // write-only frame, host drives select and clock
  task automatic spi(input logic [23:0] w, input int n);
    clk_pin = 1'b0;
    sel_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      drv = w[23-i];
      #24 clk_pin = 1'b1;
      #24 clk_pin = 1'b0;
    end
    #24 sel_pin = 1'b1;
    drv = ~drv; // inverted line shows no stale bit
    #200;
  endtask : spi
endmodule : ccp_host_model

// ==== codec_control_port_test.sv ====
// Purpose: self-checking bench of the codec control port
// Assumes: host model paces both buses
// Notes:   a byte model predicts every write and read
`timescale 1ns/1ns
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module codec_control_port_test;
  // ==================================================
  // signals
  logic        mclk;
  logic        rst_n;
  logic        spi_mode_strap;
  logic        sel;
  logic        scl;
  logic        sda;
  logic        oe;
  logic        reg_wr_pulse;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  mem [256];   // register contents model
  logic [15:0] exp_q [$];   // expected writes, addr and data
  logic [23:0] w;           // spi frame
  int          n_errors  = 0;
  int          tests_run = 0;
  assign reg_rdata = mem[reg_addr];
  ccp_top uut (
    .mclk(mclk), .rst_n(rst_n), .spi_mode_strap(spi_mode_strap), .address_low_bit(sel),
    .control_clock_pin(scl), .control_data_pin_i(sda), .control_data_pin_o(),
    .control_data_pin_oe(oe), .reg_wr_pulse(reg_wr_pulse), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );
  ccp_host_model host (.mclk(mclk), .data_oe(oe), .clk_pin(scl), .data_pin(sda), .sel_pin(sel));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // every write pulse against the queue
  always @(negedge mclk) begin
    if (reg_wr_pulse === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected write")
      else `CHK({reg_addr, reg_wdata}, exp_q.pop_front(), "write addr or data")
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic do_reset(input logic m, input logic s);
    rst_n = 1'b0;
    spi_mode_strap = m;
    host.sel_pin = s;
    host.clk_pin = !m;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (12) @(negedge mclk);
  endtask : do_reset
  // two data bytes to a random register, or a refused address
  task automatic i2c_wr(input logic [7:0] dev, input logic hit);
    logic [7:0] r, d, rb;
    logic       a;
    r = 8'($urandom);
    d = 8'($urandom);
    host.start();
    host.xfer(dev, 1'b1, rb, a);
    `CHK(a, !hit, "address acknowledge")
    if (hit) exp_q.push_back({r, d});
    if (hit) exp_q.push_back({8'(r + 8'h01), ~d});
    host.xfer(r, 1'b1, rb, a);
    host.xfer(d, 1'b1, rb, a);
    host.xfer(~d, 1'b1, rb, a);
    `CHK(a, !hit, "data acknowledge")
    host.stop();
  endtask : i2c_wr
  // two-byte read, host acks the first only
  task automatic i2c_rd(input logic [7:0] dev);
    logic [7:0] r, rb;
    logic       a;
    r = 8'($urandom);
    host.start();
    host.xfer(dev, 1'b1, rb, a);
    host.xfer(r, 1'b1, rb, a);
    host.start();
    host.xfer(dev | 8'h01, 1'b1, rb, a);
    `CHK(a, 1'b0, "read address acknowledge")
    host.xfer(8'hff, 1'b0, rb, a);
    `CHK(rb, mem[r], "first read byte")
    host.xfer(8'hff, 1'b1, rb, a);
    `CHK(rb, mem[8'(r + 8'h01)], "next read byte")
    host.stop();
  endtask : i2c_rd
  // ==================================================
  // main sequence
  initial begin
    void'($urandom(32'hb14d1473));
    foreach (mem[i]) mem[i] = 8'($urandom);
    for (int s = 0; s < 2; s++) begin
      do_reset(1'b0, s[0]);
      i2c_wr(s ? 8'h22 : 8'h20, 1'b1);
      i2c_wr(s ? 8'h20 : 8'h22, 1'b0);
      i2c_rd(s ? 8'h22 : 8'h20);
    end
    do_reset(1'b1, 1'b1);
    w = {8'h20, 8'($urandom), 8'($urandom)};
    exp_q.push_back(w[15:0]);
    host.spi(w, 24);
    host.spi({8'h22, ~w[15:0]}, 24);
    host.spi(~w, 12); // aborted frame
    exp_q.push_back(~w[15:0]);
    host.spi({8'h20, ~w[15:0]}, 24);
    repeat (20) @(negedge mclk);
    `CHK(exp_q.size(), 0, "writes missing")
    print_verdict();
  end
  // run needs about 70 us; cut a hang at 300 us
  initial begin
    #300_000;
    n_errors++;
    print_verdict();
  end
endmodule : codec_control_port_test
